/* File: hdl/ppca_regs.vh */
// Register word indices, field positions and codes of the pending page copy-accept unit.
// Assumes an Avalon-MM master that addresses 32-bit words.
`ifndef PPCA_REGS_VH
`define PPCA_REGS_VH

`define PPCA_REG_CTRL       5'h00
`define PPCA_REG_MODE       5'h01
`define PPCA_REG_ACC        5'h02
`define PPCA_REG_FLAGS      5'h03
`define PPCA_REG_DESC_LO    5'h04
`define PPCA_REG_DESC_HI    5'h05
`define PPCA_REG_DST_LO     5'h06
`define PPCA_REG_DST_HI     5'h07
`define PPCA_REG_SRC_LO     5'h08
`define PPCA_REG_SRC_HI     5'h09
`define PPCA_REG_ELR_BASE   5'h0A
`define PPCA_REG_ELR_LIMIT  5'h0B
`define PPCA_REG_SEG_LIMIT  5'h0C
`define PPCA_REG_ACTIVE_ID  5'h0D
`define PPCA_REG_EPC_BASE   5'h0E
`define PPCA_REG_FADDR_LO   5'h0F
`define PPCA_REG_FADDR_HI   5'h10
`define PPCA_REG_ATTR_IDX   5'h11
`define PPCA_REG_ATTR_DATA  5'h12
`define PPCA_REG_ATTR_MAP   5'h13
`define PPCA_REG_MEM_ADDR   5'h14
`define PPCA_REG_MEM_DATA   5'h15

`define PPCA_LEAF_COPY      32'h0000_0007
`define PPCA_MISMATCH_CODE  32'h0000_0001
`define PPCA_REGULAR_PAGE_TYPE         8'h01

`define PPCA_FAULT_NONE     2'h0
`define PPCA_FAULT_GP       2'h1
`define PPCA_FAULT_PF       2'h2
`define PPCA_FAULT_LEAF     2'h3

`define PPCA_A_VALID        0
`define PPCA_A_R            1
`define PPCA_A_W            2
`define PPCA_A_X            3
`define PPCA_A_PEND         4
`define PPCA_A_MOD          5
`define PPCA_A_BLK          6
`define PPCA_A_BUSY         7

`define PPCA_F_CF           0
`define PPCA_F_PF           2
`define PPCA_F_AF           4
`define PPCA_F_ZF           6
`define PPCA_F_SF           7
`define PPCA_F_OF           11

`define PPCA_DESC_WORDS     5'h10
`define PPCA_PAGE_WORDS     11'h400
`endif

/* File: hdl/ppca_top.v */
// Pending page copy-accept execution unit with its page attribute map and page store.
// Assumes one clock domain and an Avalon-MM master that addresses 32-bit words.
//
// Overview of operation
// - Leaf 07H in the accumulator selects copy-accept, in 32-bit and 64-bit modes.
// - Issuing it outside an enclave raises a general protection fault.
// - A descriptor pointer not aligned to 64 bytes raises a general protection fault.
// - A destination or source pointer not 4 KB aligned raises a general protection fault.
// - Any operand outside the enclave linear range raises a general protection fault.
// - Operands outside the page cache page-fault, checked descriptor, destination, source.
// - Descriptor page must be valid, readable, settled, unblocked, regular, owned, mapped.
// - The 64-byte descriptor is copied to a 512-bit scratch copy used afterwards.
// - Nonzero reserved field, write without read or non-regular type is a protection fault.
// - Source page must be valid, readable, settled, unblocked, regular, owned, mapped.
// - Destination must be valid, pending, unmodified, unblocked, regular, owned, else mismatch.
// - Destination is claimed exclusively; a page already in use is a protection fault.
// - Claimed destination is re-checked for pending, rights RW-, type, owner, mapping.
// - On success all 4 KB of the source page are copied into the destination.
// - Requested rights are written, pending cleared, zero flag and accumulator cleared.
// - Every non-faulting end clears CF, PF, AF, OF, SF; ZF set only on mismatch.
// - A lock in either mode, or without 64-bit mode an operand over the segment limit, is a fault.
// - In 64-bit mode, a non-canonical operand is a general protection fault.
// - Mismatch is reported only through zero flag and accumulator; success leaves zero.
`include "ppca_regs.vh"

module ppca_top #(
    parameter PG_N = 4,
    parameter PG_W = 2
) (
    // Clock, reset and enable.
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    // Avalon-MM slave.
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest
);

    localparam MW = PG_W + 10;
    localparam [8:0] S_IDLE = 9'h001, S_CHK1 = 9'h002, S_SCR = 9'h004, S_CHK2 = 9'h008, S_CLAIM = 9'h010,
                     S_RECHK = 9'h020, S_COPY = 9'h040, S_UPD = 9'h080, S_MISS = 9'h100;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    reg  [8:0]   state_r;
    reg          ack_r;
    reg          done_r;
    reg  [1:0]   fault_r;
    reg  [63:0]  faddr_r;
    reg  [2:0]   mode_r;
    reg  [31:0]  acc_r;
    reg  [31:0]  flags_r;
    reg  [63:0]  desc_r;
    reg  [63:0]  dst_r;
    reg  [63:0]  src_r;
    reg  [31:0]  elr_base_r;
    reg  [31:0]  elr_limit_r;
    reg  [31:0]  seg_limit_r;
    reg  [7:0]   active_id_r;
    reg  [31:0]  epc_base_r;
    reg  [PG_W-1:0] attr_idx_r;
    reg  [MW-1:0]   mem_addr_r;
    reg  [511:0] scratch_r;
    reg  [10:0]  cnt_r;
    reg  [31:0]  attr_r [0:PG_N-1];
    reg  [31:0]  map_r  [0:PG_N-1];
    reg  [31:0]  mem_r  [0:PG_N*1024-1];
    integer      i;

    wire in_encl  = mode_r[0];
    wire mode64   = mode_r[1];
    wire op_lock  = mode_r[2];
    wire busy     = ~state_r[0];
    wire acc_go   = (avs_read | avs_write) & ack_r;
    wire wr_go    = avs_write & acc_go;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding shared by the three operands.
    function in_epc;
        input [63:0] a;
        input [31:0] base;
        reg   [31:0] off;
        begin
            off    = a[31:0] - base;
            in_epc = (a[63:32] == 32'h0000_0000) && (a[31:0] >= base) && ((off >> 12) < PG_N);
        end
    endfunction

    function [PG_W-1:0] pg_of;
        input [63:0] a;
        input [31:0] base;
        reg   [31:0] off;
        begin
            off   = a[31:0] - base;
            pg_of = off[PG_W+11:12];
        end
    endfunction

    function in_range;
        input [63:0] a;
        begin
            in_range = (a[63:32] == 32'h0000_0000) && (a[31:0] >= elr_base_r) && (a[31:0] <= elr_limit_r);
        end
    endfunction

    function canon;
        input [63:0] a;
        begin
            canon = (&a[63:47]) | ~(|a[63:47]);
        end
    endfunction

    function reg_page_ok;
        input [31:0] e;
        input [31:0] m;
        input [63:0] a;
        begin
            reg_page_ok = e[`PPCA_A_VALID] & e[`PPCA_A_R] & ~e[`PPCA_A_PEND] & ~e[`PPCA_A_MOD] &
                          ~e[`PPCA_A_BLK] & (e[15:8] == `PPCA_REGULAR_PAGE_TYPE) & (e[23:16] == active_id_r) &
                          (m == {a[31:12], 12'h000});
        end
    endfunction

    wire [PG_W-1:0] d_pg = pg_of(desc_r, epc_base_r);
    wire [PG_W-1:0] t_pg = pg_of(dst_r, epc_base_r);
    wire [PG_W-1:0] s_pg = pg_of(src_r, epc_base_r);
    wire [31:0]     t_e  = attr_r[t_pg];
    wire [31:0]     s_e  = attr_r[s_pg];
    wire [MW-1:0]   d_wd = {d_pg, desc_r[11:2]};
    wire [MW-1:0]   t_wd = {t_pg, 10'h000};
    wire [MW-1:0]   s_wd = {s_pg, 10'h000};
    wire [MW-1:0]   cnt_w = {{(MW-10){1'b0}}, cnt_r[9:0]};

    ////////////////////////////////////////////////////////////////////////////
    // First check stage, in priority order.
    reg  [1:0]  chk1_f;
    reg  [63:0] chk1_a;
    always @*
    begin
        chk1_f = `PPCA_FAULT_NONE;
        chk1_a = 64'h0000_0000_0000_0000;
        if (!in_encl)
            chk1_f = `PPCA_FAULT_GP;
        else if (op_lock || (!mode64 && ((desc_r > {32'h0, seg_limit_r}) || (dst_r > {32'h0, seg_limit_r}) ||
                                         (src_r > {32'h0, seg_limit_r}))))
            chk1_f = `PPCA_FAULT_GP;
        else if (mode64 && !(canon(desc_r) && canon(dst_r) && canon(src_r)))
            chk1_f = `PPCA_FAULT_GP;
        else if (desc_r[5:0] != 6'h00)
            chk1_f = `PPCA_FAULT_GP;
        else if ((dst_r[11:0] != 12'h000) || (src_r[11:0] != 12'h000))
            chk1_f = `PPCA_FAULT_GP;
        else if (!(in_range(desc_r) && in_range(dst_r) && in_range(src_r)))
            chk1_f = `PPCA_FAULT_GP;
        else if (!in_epc(desc_r, epc_base_r))
        begin
            chk1_f = `PPCA_FAULT_PF;
            chk1_a = desc_r;
        end
        else if (!in_epc(dst_r, epc_base_r))
        begin
            chk1_f = `PPCA_FAULT_PF;
            chk1_a = dst_r;
        end
        else if (!in_epc(src_r, epc_base_r))
        begin
            chk1_f = `PPCA_FAULT_PF;
            chk1_a = src_r;
        end
        else if (!reg_page_ok(attr_r[d_pg], map_r[d_pg], desc_r))
        begin
            chk1_f = `PPCA_FAULT_PF;
            chk1_a = desc_r;
        end
    end

    wire sc_bad = (|scratch_r[511:16]) | (|scratch_r[7:5]) | (~scratch_r[0] & scratch_r[1]) |
                  (scratch_r[15:8] != `PPCA_REGULAR_PAGE_TYPE);
    wire t_first_ok = t_e[`PPCA_A_VALID] & t_e[`PPCA_A_PEND] & ~t_e[`PPCA_A_MOD] & ~t_e[`PPCA_A_BLK] &
                      (t_e[15:8] == `PPCA_REGULAR_PAGE_TYPE) & (t_e[23:16] == active_id_r);
    wire t_re_ok = t_e[`PPCA_A_VALID] & t_e[`PPCA_A_PEND] & ~t_e[`PPCA_A_MOD] & t_e[`PPCA_A_R] &
                   t_e[`PPCA_A_W] & ~t_e[`PPCA_A_X] & (t_e[15:8] == scratch_r[15:8]) &
                   (t_e[23:16] == active_id_r) & (map_r[t_pg] == dst_r[31:0]);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave read mux.
    reg  [31:0] rd_mux;
    always @*
    begin
        case (avs_address)
            `PPCA_REG_CTRL:      rd_mux = {26'h0, fault_r, 2'h0, done_r, busy};
            `PPCA_REG_MODE:      rd_mux = {29'h0, mode_r};
            `PPCA_REG_ACC:       rd_mux = acc_r;
            `PPCA_REG_FLAGS:     rd_mux = flags_r;
            `PPCA_REG_DESC_LO:   rd_mux = desc_r[31:0];
            `PPCA_REG_DESC_HI:   rd_mux = desc_r[63:32];
            `PPCA_REG_DST_LO:    rd_mux = dst_r[31:0];
            `PPCA_REG_DST_HI:    rd_mux = dst_r[63:32];
            `PPCA_REG_SRC_LO:    rd_mux = src_r[31:0];
            `PPCA_REG_SRC_HI:    rd_mux = src_r[63:32];
            `PPCA_REG_ELR_BASE:  rd_mux = elr_base_r;
            `PPCA_REG_ELR_LIMIT: rd_mux = elr_limit_r;
            `PPCA_REG_SEG_LIMIT: rd_mux = seg_limit_r;
            `PPCA_REG_ACTIVE_ID: rd_mux = {24'h0, active_id_r};
            `PPCA_REG_EPC_BASE:  rd_mux = epc_base_r;
            `PPCA_REG_FADDR_LO:  rd_mux = faddr_r[31:0];
            `PPCA_REG_FADDR_HI:  rd_mux = faddr_r[63:32];
            `PPCA_REG_ATTR_IDX:  rd_mux = {{(32-PG_W){1'b0}}, attr_idx_r};
            `PPCA_REG_ATTR_DATA: rd_mux = attr_r[attr_idx_r];
            `PPCA_REG_ATTR_MAP:  rd_mux = map_r[attr_idx_r];
            `PPCA_REG_MEM_ADDR:  rd_mux = {{(32-MW){1'b0}}, mem_addr_r};
            `PPCA_REG_MEM_DATA:  rd_mux = mem_r[mem_addr_r];
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-owned configuration; operand registers are held while busy.
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            mode_r       <= 3'h0;
            desc_r       <= 64'h0;
            dst_r        <= 64'h0;
            src_r        <= 64'h0;
            elr_base_r   <= 32'h0000_0000;
            elr_limit_r  <= 32'h0000_0000;
            seg_limit_r  <= 32'hFFFF_FFFF;
            active_id_r  <= 8'h00;
            epc_base_r   <= 32'h0000_0000;
            attr_idx_r   <= {PG_W{1'b0}};
            mem_addr_r   <= {MW{1'b0}};
        end
        else if (clk_en)
        begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
            if ((avs_read | avs_write) && !ack_r)
                avs_readdata <= rd_mux;
            if (wr_go && !busy)
            begin
                case (avs_address)
                    `PPCA_REG_MODE:      mode_r      <= avs_writedata[2:0];
                    `PPCA_REG_DESC_LO:   desc_r[31:0]  <= avs_writedata;
                    `PPCA_REG_DESC_HI:   desc_r[63:32] <= avs_writedata;
                    `PPCA_REG_DST_LO:    dst_r[31:0]   <= avs_writedata;
                    `PPCA_REG_DST_HI:    dst_r[63:32]  <= avs_writedata;
                    `PPCA_REG_SRC_LO:    src_r[31:0]   <= avs_writedata;
                    `PPCA_REG_SRC_HI:    src_r[63:32]  <= avs_writedata;
                    `PPCA_REG_ELR_BASE:  elr_base_r  <= avs_writedata;
                    `PPCA_REG_ELR_LIMIT: elr_limit_r <= avs_writedata;
                    `PPCA_REG_SEG_LIMIT: seg_limit_r <= avs_writedata;
                    `PPCA_REG_ACTIVE_ID: active_id_r <= avs_writedata[7:0];
                    `PPCA_REG_EPC_BASE:  epc_base_r  <= avs_writedata;
                    default:             ;
                endcase
            end
            if (wr_go && avs_address == `PPCA_REG_ATTR_IDX)
                attr_idx_r <= avs_writedata[PG_W-1:0];
            if (wr_go && avs_address == `PPCA_REG_MEM_ADDR)
                mem_addr_r <= avs_writedata[MW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer, result registers, attribute map and page store.
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_r   <= S_IDLE;
            done_r    <= 1'b0;
            fault_r   <= `PPCA_FAULT_NONE;
            faddr_r   <= 64'h0;
            acc_r     <= 32'h0000_0000;
            flags_r   <= 32'h0000_0000;
            scratch_r <= 512'h0;
            cnt_r     <= 11'h000;
            for (i = 0; i < PG_N; i = i + 1)
            begin
                attr_r[i] <= 32'h0000_0000;
                map_r[i]  <= 32'h0000_0000;
            end
        end
        else if (clk_en)
        begin
            // The sequencer owns the page store while busy, so software writes there are dropped.
            if (wr_go && !busy)
            begin
                case (avs_address)
                    `PPCA_REG_ACC:       acc_r <= avs_writedata;
                    `PPCA_REG_FLAGS:     flags_r <= avs_writedata;
                    `PPCA_REG_ATTR_DATA: attr_r[attr_idx_r] <= avs_writedata;
                    `PPCA_REG_ATTR_MAP:  map_r[attr_idx_r] <= avs_writedata;
                    `PPCA_REG_MEM_DATA:  mem_r[mem_addr_r] <= avs_writedata;
                    default:             ;
                endcase
            end
            case (state_r)
                S_IDLE:
                begin
                    if (wr_go && avs_address == `PPCA_REG_CTRL && avs_writedata[0])
                    begin
                        done_r  <= 1'b0;
                        fault_r <= `PPCA_FAULT_NONE;
                        if (acc_r == `PPCA_LEAF_COPY)
                            state_r <= S_CHK1;
                        else
                        begin
                            fault_r <= `PPCA_FAULT_LEAF;
                            done_r  <= 1'b1;
                        end
                    end
                end
                S_CHK1:
                begin
                    cnt_r <= 11'h000;
                    if (chk1_f != `PPCA_FAULT_NONE)
                    begin
                        fault_r <= chk1_f;
                        faddr_r <= chk1_a;
                        done_r  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                    else
                        state_r <= S_SCR;
                end
                S_SCR:
                begin
                    scratch_r <= {mem_r[d_wd + cnt_w], scratch_r[511:32]};
                    cnt_r     <= cnt_r + 11'h001;
                    if (cnt_r == {6'h00, `PPCA_DESC_WORDS} - 11'h001)
                        state_r <= S_CHK2;
                end
                S_CHK2:
                begin
                    cnt_r   <= 11'h000;
                    done_r  <= sc_bad | ~reg_page_ok(s_e, map_r[s_pg], src_r);
                    state_r <= S_CLAIM;
                    if (sc_bad)
                    begin
                        fault_r <= `PPCA_FAULT_GP;
                        state_r <= S_IDLE;
                    end
                    else if (!reg_page_ok(s_e, map_r[s_pg], src_r))
                    begin
                        fault_r <= `PPCA_FAULT_PF;
                        faddr_r <= src_r;
                        state_r <= S_IDLE;
                    end
                    else if (!t_first_ok)
                        state_r <= S_MISS;
                end
                S_CLAIM:
                begin
                    if (t_e[`PPCA_A_BUSY])
                    begin
                        fault_r <= `PPCA_FAULT_GP;
                        done_r  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                    else
                    begin
                        attr_r[t_pg][`PPCA_A_BUSY] <= 1'b1;
                        state_r <= S_RECHK;
                    end
                end
                S_RECHK:
                begin
                    if (t_re_ok)
                        state_r <= S_COPY;
                    else
                    begin
                        attr_r[t_pg][`PPCA_A_BUSY] <= 1'b0;
                        state_r <= S_MISS;
                    end
                end
                S_COPY:
                begin
                    mem_r[t_wd + cnt_w] <= mem_r[s_wd + cnt_w];
                    cnt_r <= cnt_r + 11'h001;
                    if (cnt_r == `PPCA_PAGE_WORDS - 11'h001)
                        state_r <= S_UPD;
                end
                S_UPD:
                begin
                    attr_r[t_pg][`PPCA_A_R]    <= scratch_r[0];
                    attr_r[t_pg][`PPCA_A_W]    <= scratch_r[1];
                    attr_r[t_pg][`PPCA_A_X]    <= scratch_r[2];
                    attr_r[t_pg][`PPCA_A_PEND] <= 1'b0;
                    attr_r[t_pg][`PPCA_A_BUSY] <= 1'b0;
                    acc_r <= 32'h0000_0000;
                    flags_r[`PPCA_F_ZF] <= 1'b0;
                    flags_r[`PPCA_F_CF] <= 1'b0;
                    flags_r[`PPCA_F_PF] <= 1'b0;
                    flags_r[`PPCA_F_AF] <= 1'b0;
                    flags_r[`PPCA_F_OF] <= 1'b0;
                    flags_r[`PPCA_F_SF] <= 1'b0;
                    done_r  <= 1'b1;
                    state_r <= S_IDLE;
                end
                S_MISS:
                begin
                    acc_r <= `PPCA_MISMATCH_CODE;
                    flags_r[`PPCA_F_ZF] <= 1'b1;
                    flags_r[`PPCA_F_CF] <= 1'b0;
                    flags_r[`PPCA_F_PF] <= 1'b0;
                    flags_r[`PPCA_F_AF] <= 1'b0;
                    flags_r[`PPCA_F_OF] <= 1'b0;
                    flags_r[`PPCA_F_SF] <= 1'b0;
                    done_r  <= 1'b1;
                    state_r <= S_IDLE;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule

/* File: sim/ppca_props.sv */
// Bus port checks of the copy-accept unit.
// Assumes it is bound to ppca_top, which has one clock domain.
module ppca_props (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire        clk_en,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    wire req = avs_read | avs_write;
    wire rd_ok = avs_read & ~avs_waitrequest;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_idle_no_wait: assert property (!req |-> !avs_waitrequest)
        else $error("wait without request");
    a_first_wait: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_one_wait: assert property (req && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("wait too long");
    a_rdata_hold: assert property (!req |=> $stable(avs_readdata))
        else $error("read data moved");
    a_rst_rdata: assert property (disable iff (1'b0) sys_rst && clk_en |=> avs_readdata == 32'h0)
        else $error("read data not cleared");
    a_unmapped_zero: assert property (rd_ok && avs_address > 5'h15 |-> avs_readdata == 32'h0)
        else $error("unmapped read nonzero");
    a_flags_only_zf: assert property (rd_ok && avs_address == 5'h03 |-> (avs_readdata & 32'hFFFF_FFBF) == 32'h0)
        else $error("flag other than zero set");
    a_freeze_rdata: assert property (!clk_en |=> $stable(avs_readdata))
        else $error("read data moved while frozen");
    c_done: cover property (rd_ok && avs_address == 5'h00 && avs_readdata[1]);
    c_zf: cover property (rd_ok && avs_address == 5'h03 && avs_readdata[6]);
    c_pf: cover property (rd_ok && avs_address == 5'h00 && avs_readdata[5:4] == 2'h2);
endmodule
bind ppca_top ppca_props u_props (.ref_clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);

/* File: sim/ppca_sw_model.sv */
// Software-side master issuing register accesses to the copy-accept unit.
// Assumes waitrequest is sampled on rising edges; the bench timeout ends a hang.
module ppca_sw_model (
    input  wire         ref_clk,
    input  wire         avs_waitrequest,
    input  wire  [31:0] avs_readdata,
    output logic [4:0]  avs_address = 5'h00,
    output logic        avs_read = 1'b0,
    output logic        avs_write = 1'b0,
    output logic [31:0] avs_writedata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // The request is held until the edge that sees waitrequest low, then dropped for a cycle.
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    begin
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask
endmodule

/* File: sim/ppca_top_tb.sv */
// Self-checking bench of the pending page copy-accept unit.
// Assumes ppca_top and the master model ppca_sw_model.
module ppca_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    wire  [4:0]  avs_address;
    wire         avs_read;
    wire         avs_write;
    wire  [31:0] avs_writedata;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    int          err_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [31:0] lfsr = 32'h06AB_D650;
    logic [31:0] rv;
    logic [31:0] flags_m = 32'h0;
    logic [31:0] src_q[$];
    logic [31:0] cfg[15] = '{32'h0, 32'h1, 32'h7, 32'h0, 32'h1_0000, 32'h0, 32'h1_2000, 32'h0, 32'h1_1000,
                             32'h0, 32'h1_0000, 32'h1_FFFF, 32'hFFFF_FFFF, 32'h3, 32'h1_0000};
    ppca_top u_dut (.ref_clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest);
    ppca_sw_model u_sw (.ref_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
        .avs_writedata);
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (++cyc == 40000)
        begin
            err_count++;
            end_sim();
        end
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        u_sw.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [4:0] a);
        u_sw.xfer(1'b0, a, 32'h0, rv);
    endtask
    task automatic chk(input string n, input logic [31:0] e);
        comparisons++;
        if (rv !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, rv);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Loads a clean request, applies two tweaks, runs it and checks the reported outcome.
    task automatic run(input logic [4:0] a1, input logic [31:0] d1, input logic [4:0] a2, input logic [31:0] d2,
                       input logic [1:0] f, input logic z, input logic [31:0] fa);
        for (int i = 1; i < 15; i++)
            if (i != 3)
                wr(5'(i), cfg[i]);
        for (int i = 0; i < 16; i++)
        begin
            wr(5'h14, 32'(i));
            wr(5'h15, (i == 0) ? 32'h0000_0105 : 32'h0);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(5'h11, 32'(i));
            wr(5'h13, 32'h1_0000 + 32'(i) * 32'h1000);
            wr(5'h12, (i == 2) ? 32'h0003_0117 : 32'h0003_0103);
        end
        wr(a1, d1);
        wr(a2, d2);
        wr(5'h00, 32'h1);
        rv = 32'h1;
        while (rv[0] !== 1'b0)
        begin
            lfsr = step(lfsr);
            clk_en <= lfsr[0];
            @(posedge ref_clk);
            clk_en <= 1'b1;
            rd(5'h00);
        end
        rv = rv & 32'h33;
        chk("status", {26'h0, f, 4'h2});
        if (f == 2'h0)
            flags_m = {25'h0, z, 6'h0};
        rd(5'h03);
        chk("flags", flags_m);
        rd(5'h02);
        chk("result", (f == 2'h3) ? 32'h5 : (f != 2'h0) ? 32'h7 : {31'h0, z});
        if (f == 2'h2)
        begin
            rd(5'h0F);
            chk("fault address", fa);
        end
        for (int i = 0; i < ((f == 2'h0 && !z) ? 1024 : 1); i++)
        begin
            wr(5'h14, 32'(2048 + i));
            rd(5'h15);
            chk("target word", (f == 2'h0 && !z) ? src_q[i] : 32'h5A5A_5A5A);
        end
        wr(5'h11, 32'h2);
        rd(5'h12);
        chk("target entry", (f == 2'h0 && !z) ? 32'h0003_010B : (a1 == 5'h12) ? d1 : 32'h0003_0117);
        $display("test end: fault %0d, zero flag %0d", f, z);
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 1024; i++)
        begin
            lfsr = step(lfsr);
            src_q.push_back(lfsr);
            wr(5'h14, 32'(1024 + i));
            wr(5'h15, lfsr);
        end
        wr(5'h14, 32'h800);
        wr(5'h15, 32'h5A5A_5A5A);
        rd(5'h1F);
        chk("unmapped read", 32'h0);
        run(5'h02, 32'h5, 5'h1F, 32'h0, 2'h3, 1'b0, 32'h0);
        run(5'h12, 32'h0003_0107, 5'h1F, 32'h0, 2'h0, 1'b1, 32'h0);
        run(5'h01, 32'h0, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h04, 32'h1_0020, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h06, 32'h1_2010, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h08, 32'h4_0000, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h08, 32'h1_4000, 5'h1F, 32'h0, 2'h2, 1'b0, 32'h1_4000);
        run(5'h11, 32'h0, 5'h12, 32'h0003_0113, 2'h2, 1'b0, 32'h1_0000);
        run(5'h14, 32'h1, 5'h15, 32'h1, 2'h1, 1'b0, 32'h0);
        run(5'h14, 32'h0, 5'h15, 32'h102, 2'h1, 1'b0, 32'h0);
        run(5'h14, 32'h0, 5'h15, 32'h205, 2'h1, 1'b0, 32'h0);
        run(5'h11, 32'h1, 5'h12, 32'h0003_0101, 2'h2, 1'b0, 32'h1_1000);
        run(5'h12, 32'h0003_0197, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h12, 32'h0003_011F, 5'h1F, 32'h0, 2'h0, 1'b1, 32'h0);
        run(5'h01, 32'h5, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h0C, 32'h1_1000, 5'h1F, 32'h0, 2'h1, 1'b0, 32'h0);
        run(5'h01, 32'h3, 5'h07, 32'h8000, 2'h1, 1'b0, 32'h0);
        run(5'h1F, 32'h0, 5'h1F, 32'h0, 2'h0, 1'b0, 32'h0);
        end_sim();
    end
endmodule
